// ---- design/ptm_regs.svh ----
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH

// Register word addresses on the plain register port.
`define PTM_ADDR_CTRL_EVEN 4'h0
`define PTM_ADDR_CTRL_ODD  4'h1
`define PTM_ADDR_CNT_EVEN  4'h2
`define PTM_ADDR_CNT_ODD   4'h3
`define PTM_ADDR_PER_EVEN  4'h4
`define PTM_ADDR_PER_ODD   4'h5
`define PTM_ADDR_STATUS    4'h6
`define PTM_ADDR_MASK      4'h7

// Control register field positions.
`define PTM_BIT_RUN    15
`define PTM_BIT_IDLE   13
`define PTM_BIT_GATE   6
`define PTM_BIT_PSC_HI 5
`define PTM_BIT_PSC_LO 4
`define PTM_BIT_JOIN   3
`define PTM_BIT_CLKSRC 1

// Writable bits of each control register; all others read as zero.
`define PTM_CTRL_WMASK_EVEN 16'hA07A
`define PTM_CTRL_WMASK_ODD  16'hA072

// Status and mask register bit positions.
`define PTM_ST_EVEN 0
`define PTM_ST_ODD  1

// Reset values.
`define PTM_CTRL_RST   16'h0000
`define PTM_COUNT_RST  16'h0000
`define PTM_PERIOD_RST 16'hFFFF
`define PTM_FLAGS_RST  2'h0

// Prescale select codes and their last prescale count.
`define PTM_PSC_1   2'h0
`define PTM_PSC_8   2'h1
`define PTM_PSC_64  2'h2
`define PTM_PSC_256 2'h3
`define PTM_LAST_1   8'h00
`define PTM_LAST_8   8'h07
`define PTM_LAST_64  8'h3F
`define PTM_LAST_256 8'hFF

`endif

// ---- design/ptm_pkg.sv ----
package ptm_pkg;

  // Decoded fields of one timer control register.
  typedef struct packed {
    logic       run_bit;
    logic       idle_halt_select;
    logic       gated_accumulate_enable;
    logic [1:0] prescale_select;
    logic       pair_join_select;
    logic       clock_source_select;
  } ptm_ctrl_t;

  // Count events produced by one timer channel.
  typedef struct packed {
    logic tick;
    logic gate_fall;
  } ptm_evt_t;

endpackage

// ---- design/ptm_pair.sv ----
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "ptm_regs.svh"

module ptm_chan
  import ptm_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      srst_i,
  input  wire logic      ce_i,
  input  wire ptm_ctrl_t ctrl_i,
  input  wire logic      idle_i,
  input  wire logic      ext_i,
  input  wire logic      gate_i,
  input  wire logic      psc_clr_i,
  output ptm_evt_t       evt_o
);

  logic       ext_q;
  logic       gate_q;
  logic [7:0] psc_cnt;
  logic [7:0] psc_last;

  wire active    = ctrl_i.run_bit & ~(ctrl_i.idle_halt_select & idle_i);
  wire gated     = ctrl_i.gated_accumulate_enable & ~ctrl_i.clock_source_select;
  wire ext_rise  = ext_i & ~ext_q;
  // The external source is sampled on clk_i, so counting stays synchronous.
  wire src_pulse = ctrl_i.clock_source_select ? ext_rise : (~gated | gate_i);
  wire psc_done  = psc_cnt == psc_last;

  assign psc_last = (ctrl_i.prescale_select == `PTM_PSC_256) ? `PTM_LAST_256 :
                    (ctrl_i.prescale_select == `PTM_PSC_64)  ? `PTM_LAST_64  :
                    (ctrl_i.prescale_select == `PTM_PSC_8)   ? `PTM_LAST_8   :
                    `PTM_LAST_1;

  assign evt_o.tick      = ce_i & active & src_pulse & psc_done & ~psc_clr_i;
  assign evt_o.gate_fall = ce_i & active & gated & gate_q & ~gate_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_q  <= 1'b0;
      gate_q <= 1'b0;
    end else if (ce_i) begin
      ext_q  <= ext_i;
      gate_q <= gate_i;
    end
  end

  // A stopped timer also drops its partial prescale count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      psc_cnt <= 8'h00;
    end else if (ce_i) begin
      if (psc_clr_i || !active) begin
        psc_cnt <= 8'h00;
      end else if (src_pulse) begin
        psc_cnt <= psc_done ? 8'h00 : psc_cnt + 8'h01;
      end
    end
  end

endmodule

module ptm_pair
  import ptm_pkg::*;
#(
  parameter bit LOWER_PAIR = 1'b1
)
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        idle_i,
  input  wire logic        external_count_input_i,
  input  wire logic        gate_i,
  input  wire logic        odd_external_count_input_i,
  input  wire logic        odd_gate_i,
  output logic             irq_o,
  output logic             conv_trigger_o
);

  logic [15:0] ctrl_even;
  logic [15:0] ctrl_odd;
  logic [15:0] cnt_even;
  logic [15:0] cnt_odd;
  logic [15:0] per_even;
  logic [15:0] per_odd;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [15:0] next_cnt_even;
  logic [15:0] next_cnt_odd;
  logic [15:0] rd_mux;
  ptm_ctrl_t   cf_even;
  ptm_ctrl_t   cf_odd;
  ptm_evt_t    ev_even;
  ptm_evt_t    ev_odd;

  assign cf_even = '{run_bit:                 ctrl_even[`PTM_BIT_RUN],
                     idle_halt_select:        ctrl_even[`PTM_BIT_IDLE],
                     gated_accumulate_enable: ctrl_even[`PTM_BIT_GATE],
                     prescale_select:         ctrl_even[`PTM_BIT_PSC_HI:`PTM_BIT_PSC_LO],
                     pair_join_select:        ctrl_even[`PTM_BIT_JOIN],
                     clock_source_select:     ctrl_even[`PTM_BIT_CLKSRC]};
  assign cf_odd  = '{run_bit:                 ctrl_odd[`PTM_BIT_RUN],
                     idle_halt_select:        ctrl_odd[`PTM_BIT_IDLE],
                     gated_accumulate_enable: ctrl_odd[`PTM_BIT_GATE],
                     prescale_select:         ctrl_odd[`PTM_BIT_PSC_HI:`PTM_BIT_PSC_LO],
                     pair_join_select:        1'b0,
                     clock_source_select:     ctrl_odd[`PTM_BIT_CLKSRC]};

  wire joined = cf_even.pair_join_select;

  // Register port decode.
  wire wr_ctrl_e = wr_i && (addr_i == `PTM_ADDR_CTRL_EVEN);
  wire wr_ctrl_o = wr_i && (addr_i == `PTM_ADDR_CTRL_ODD);
  wire wr_cnt_e  = wr_i && (addr_i == `PTM_ADDR_CNT_EVEN);
  wire wr_cnt_o  = wr_i && (addr_i == `PTM_ADDR_CNT_ODD);
  wire wr_per_e  = wr_i && (addr_i == `PTM_ADDR_PER_EVEN);
  wire wr_per_o  = wr_i && (addr_i == `PTM_ADDR_PER_ODD);
  wire wr_mask   = wr_i && (addr_i == `PTM_ADDR_MASK);
  wire rd_status = rd_i && (addr_i == `PTM_ADDR_STATUS);

  // The odd prescaler is left alone while joined, since its controls are dead.
  wire clr_psc_e = wr_ctrl_e & cf_even.run_bit;
  wire clr_psc_o = wr_ctrl_o & cf_odd.run_bit & ~joined;

  ptm_chan u_even (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .ctrl_i    (cf_even),
    .idle_i    (idle_i),
    .ext_i     (external_count_input_i),
    .gate_i    (gate_i),
    .psc_clr_i (clr_psc_e),
    .evt_o     (ev_even)
  );

  ptm_chan u_odd (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .ctrl_i    (cf_odd),
    .idle_i    (idle_i),
    .ext_i     (odd_external_count_input_i),
    .gate_i    (odd_gate_i),
    .psc_clr_i (clr_psc_o),
    .evt_o     (ev_odd)
  );

  wire [31:0] cnt32   = {cnt_odd, cnt_even};
  wire [31:0] per32   = {per_odd, per_even};
  wire        hit32   = cnt32 == per32;
  wire        hit_e   = cnt_even == per_even;
  wire        hit_o   = cnt_odd == per_odd;
  wire [31:0] inc32   = hit32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
  wire        tick32  = joined & ev_even.tick;
  wire        tick_e  = ~joined & ev_even.tick;
  wire        tick_o  = ~joined & ev_odd.tick;
  wire        gated_e = cf_even.gated_accumulate_enable & ~cf_even.clock_source_select;
  wire        gated_o = cf_odd.gated_accumulate_enable & ~cf_odd.clock_source_select;
  wire        match32 = tick32 & hit32;
  wire        match_e = tick_e & hit_e;
  wire        match_o = tick_o & hit_o;

  // Gated mode flags the gate's falling edge, not the period match.
  wire evt_e = ~joined & (gated_e ? ev_even.gate_fall : match_e);
  wire evt_o = joined ? (gated_e ? ev_even.gate_fall : match32)
                      : (gated_o ? ev_odd.gate_fall : match_o);
  wire trig_evt = LOWER_PAIR & (joined ? match32 : match_o);

  always_comb begin
    next_cnt_even = cnt_even;
    next_cnt_odd  = cnt_odd;
    if (tick32) begin
      next_cnt_even = inc32[15:0];
      next_cnt_odd  = inc32[31:16];
    end
    if (tick_e) begin
      next_cnt_even = hit_e ? 16'h0000 : cnt_even + 16'h0001;
    end
    if (tick_o) begin
      next_cnt_odd = hit_o ? 16'h0000 : cnt_odd + 16'h0001;
    end
    if (wr_cnt_e) begin
      next_cnt_even = wdata_i;
    end
    if (wr_cnt_o) begin
      next_cnt_odd = wdata_i;
    end
  end

  // Set beats the read-clear, so an event in the read cycle survives.
  wire [1:0] next_status = (status & ~{2{rd_status}}) | {evt_o, evt_e};

  assign rd_mux = (addr_i == `PTM_ADDR_CTRL_EVEN) ? ctrl_even :
                  (addr_i == `PTM_ADDR_CTRL_ODD)  ? ctrl_odd  :
                  (addr_i == `PTM_ADDR_CNT_EVEN)  ? cnt_even  :
                  (addr_i == `PTM_ADDR_CNT_ODD)   ? cnt_odd   :
                  (addr_i == `PTM_ADDR_PER_EVEN)  ? per_even  :
                  (addr_i == `PTM_ADDR_PER_ODD)   ? per_odd   :
                  (addr_i == `PTM_ADDR_STATUS)    ? {14'h0000, status} :
                  (addr_i == `PTM_ADDR_MASK)      ? {14'h0000, mask} :
                  16'h0000;

  assign irq_o = |(status & mask);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_even <= `PTM_CTRL_RST;
      ctrl_odd  <= `PTM_CTRL_RST;
      per_even  <= `PTM_PERIOD_RST;
      per_odd   <= `PTM_PERIOD_RST;
      mask      <= `PTM_FLAGS_RST;
    end else if (ce_i) begin
      if (wr_ctrl_e) ctrl_even <= wdata_i & `PTM_CTRL_WMASK_EVEN;
      if (wr_ctrl_o) ctrl_odd  <= wdata_i & `PTM_CTRL_WMASK_ODD;
      if (wr_per_e)  per_even  <= wdata_i;
      if (wr_per_o)  per_odd   <= wdata_i;
      if (wr_mask)   mask      <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_even       <= `PTM_COUNT_RST;
      cnt_odd        <= `PTM_COUNT_RST;
      status         <= `PTM_FLAGS_RST;
      rdata_o        <= 16'h0000;
      conv_trigger_o <= 1'b0;
    end else if (ce_i) begin
      cnt_even       <= next_cnt_even;
      cnt_odd        <= next_cnt_odd;
      status         <= next_status;
      rdata_o        <= rd_i ? rd_mux : 16'h0000;
      conv_trigger_o <= trig_evt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  wire no_cnt_wr = ~wr_cnt_e & ~wr_cnt_o;

  sequence seq_wrap32;
    match32 && no_cnt_wr && ce_i;
  endsequence

  sequence seq_step32;
    tick32 && !hit32 && no_cnt_wr && ce_i;
  endsequence

  sequence seq_gate_fall_even;
    !joined && gated_e && ev_even.gate_fall;
  endsequence

  chk_join_wrap: assert property (seq_wrap32 |=> cnt32 == 32'h0000_0000)
    else $error("joined counter did not wrap to zero at period");
  chk_join_carry: assert property (seq_step32 |=> cnt32 == $past(cnt32) + 32'h0000_0001)
    else $error("joined counter did not step by one");
  chk_odd_flag_joined: assert property (seq_wrap32 ##0 !gated_e |=> status[`PTM_ST_ODD])
    else $error("joined match did not set odd flag");
  chk_even_flag_silent: assert property (joined && ce_i && !rd_status
                                         && !status[`PTM_ST_EVEN] |=> !status[`PTM_ST_EVEN])
    else $error("even flag set while joined");
  chk_idle_halt: assert property (cf_even.idle_halt_select && idle_i |-> !ev_even.tick)
    else $error("timer ticked while halted in idle");
  chk_run_stop: assert property (!cf_even.run_bit |-> !ev_even.tick && !ev_even.gate_fall)
    else $error("stopped timer produced an event");
  chk_gate_block: assert property (!cf_even.clock_source_select && cf_even.gated_accumulate_enable
                                   && !gate_i |-> !ev_even.tick)
    else $error("gated timer ticked with gate low");
  chk_gate_flag: assert property (seq_gate_fall_even |=> status[`PTM_ST_EVEN])
    else $error("gate falling edge did not set flag");
  chk_psc_clear: assert property (clr_psc_e && ce_i |=> u_even.psc_cnt == 8'h00)
    else $error("control write did not clear prescaler");
  chk_trig_source: assert property (conv_trigger_o |-> $past(trig_evt))
    else $error("converter trigger without lower pair match");
  chk_odd_hold: assert property (joined && ce_i && !tick32 && no_cnt_wr |=> $stable(cnt_odd))
    else $error("odd count moved without joined tick");
  chk_psc_clear_odd: assert property (clr_psc_o && ce_i |=> u_odd.psc_cnt == 8'h00)
    else $error("odd control write did not clear prescaler");
  chk_odd_idle: assert property (cf_odd.idle_halt_select && idle_i |-> !ev_odd.tick)
    else $error("odd timer ticked while halted in idle");
  chk_odd_stop: assert property (!cf_odd.run_bit |-> !ev_odd.tick && !ev_odd.gate_fall)
    else $error("stopped odd timer produced an event");
  chk_join_mute_odd: assert property (joined |-> !tick_o && !tick_e)
    else $error("separate timer ticked while joined");
  chk_even_wrap: assert property (tick_e && hit_e && !wr_cnt_e && ce_i |=> cnt_even == 16'h0000)
    else $error("even counter did not wrap at period");
  chk_odd_wrap: assert property (tick_o && hit_o && !wr_cnt_o && ce_i |=> cnt_odd == 16'h0000)
    else $error("odd counter did not wrap at period");
  chk_ext_edge: assert property (cf_even.clock_source_select
                                 && !(external_count_input_i && !u_even.ext_q)
                                 |-> !ev_even.tick)
    else $error("external clock ticked without a rising edge");
  chk_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
    else $error("read data stood without a read");

endmodule

// ---- tb/ptm_pin_model.sv ----
`timescale 1ns/10ps
// Far-side pin driver; the count pin rests low whenever half_i is zero.
module ptm_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] half_i,
  input  wire logic       gate_req_i,
  output logic            count_o,
  output logic            gate_o
);
  logic [7:0] cnt = 8'h00;
  initial count_o = 1'b0;
  initial gate_o = 1'b0;
  always @(posedge clk_i) begin
    gate_o <= gate_req_i;
    if (half_i == 8'h00) begin
      cnt     <= 8'h00;
      count_o <= 1'b0;
    end else if (cnt + 8'h01 >= half_i) begin
      cnt     <= 8'h00;
      count_o <= ~count_o;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ---- tb/test_paired_timer_16_32bit.sv ----
`timescale 1ns/10ps
`include "ptm_regs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", n, e, s); end end
module test_paired_timer_16_32bit;
  logic        clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        idle_i = 1'b0, gate_e = 1'b0, irq_o, conv_trigger_o;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, d;
  logic [7:0]  half_e = 8'h00, half_o = 8'h00;
  logic        ext_e, gt_e, ext_o, gt_o;
  logic [31:0] seed = 32'ha9f4_9a0a;
  int          mismatches = 0, checked = 0, cyc = 0, trig_n = 0, t0, t1, tn;

  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  always @(posedge clk_i) if (conv_trigger_o === 1'b1) trig_n <= trig_n + 1;

  ptm_pair #(.LOWER_PAIR(1'b1)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
    .external_count_input_i(ext_e), .gate_i(gt_e),
    .odd_external_count_input_i(ext_o), .odd_gate_i(gt_o),
    .irq_o(irq_o), .conv_trigger_o(conv_trigger_o));
  ptm_pin_model pin_e (.clk_i(clk_i), .half_i(half_e), .gate_req_i(gate_e),
    .count_o(ext_e), .gate_o(gt_e));
  ptm_pin_model pin_o (.clk_i(clk_i), .half_i(half_o), .gate_req_i(1'b0),
    .count_o(ext_o), .gate_o(gt_o));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int gap(int per, int code);
    return (per + 1) * (code == 0 ? 1 : code == 1 ? 8 : code == 2 ? 64 : 256);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Waits for the trigger pulse or the interrupt level, bounded.
  task automatic hit(input bit trig, output int t);
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk_i);
      #1;
      if ((trig ? conv_trigger_o : irq_o) === 1'b1) begin
        t = cyc;
        return;
      end
    end
    mismatches++;
    conclude();
  endtask

  initial begin
    logic [15:0] p, v;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`PTM_ADDR_PER_EVEN);
    `CHK("per_rst", `PTM_PERIOD_RST, d)
    rd(`PTM_ADDR_CTRL_EVEN);
    `CHK("ctrl_rst", `PTM_CTRL_RST, d)
    wr(4'hC, 16'hFFFF);
    rd(4'hC);
    `CHK("unmapped", 16'h0000, d)
    wr(`PTM_ADDR_CTRL_ODD, 16'hFFFF);
    rd(`PTM_ADDR_CTRL_ODD);
    `CHK("ctrl_odd_bits", `PTM_CTRL_WMASK_ODD, d)
    wr(`PTM_ADDR_CTRL_ODD, 16'h0000);
    // Mask clear: flag must be stored without raising the interrupt.
    wr(`PTM_ADDR_PER_EVEN, 16'h0003);
    wr(`PTM_ADDR_CTRL_EVEN, 16'h8000);
    repeat (20) @(posedge clk_i);
    `CHK("irq_masked", 1'b0, irq_o)
    rd(`PTM_ADDR_STATUS);
    `CHK("st_masked", 1'b1, d[0])
    wr(`PTM_ADDR_MASK, 16'h0001);
    tn = trig_n;
    for (int k = 0; k < 4; k++) begin
      p = 16'(rnd() % 8 + 3);
      wr(`PTM_ADDR_CTRL_EVEN, 16'h0000);
      wr(`PTM_ADDR_CNT_EVEN, 16'h0000);
      wr(`PTM_ADDR_PER_EVEN, p);
      rd(`PTM_ADDR_STATUS);
      wr(`PTM_ADDR_CTRL_EVEN, {1'b1, 9'h000, 2'(k), 4'h0});
      hit(1'b0, t0);
      rd(`PTM_ADDR_STATUS);
      `CHK("st_even", 16'h0001, d)
      hit(1'b0, t1);
      rd(`PTM_ADDR_STATUS);
      `CHK("gap_even", gap(int'(p), k), t1 - t0)
    end
    `CHK("no_trig_even", tn, trig_n)
    // Odd timer alone on external edges from the slow or prompt far side.
    wr(`PTM_ADDR_CTRL_EVEN, 16'h0000);
    half_o <= 8'(rnd() % 3 + 1);
    wr(`PTM_ADDR_PER_ODD, 16'h0003);
    wr(`PTM_ADDR_CTRL_ODD, 16'h8012);
    hit(1'b1, t0);
    hit(1'b1, t1);
    `CHK("gap_odd_ext", gap(3, 1) * 2 * int'(half_o), t1 - t0)
    // Joined pair; odd control gets stray bits that must be ignored.
    wr(`PTM_ADDR_MASK, 16'h0003);
    wr(`PTM_ADDR_CTRL_EVEN, 16'h0008);
    wr(`PTM_ADDR_CTRL_ODD, 16'((rnd() & 32'h0000_A072) | 32'h0000_8030));
    wr(`PTM_ADDR_CNT_EVEN, 16'hFFF0);
    wr(`PTM_ADDR_CNT_ODD, 16'h0000);
    wr(`PTM_ADDR_PER_EVEN, 16'h0020);
    wr(`PTM_ADDR_PER_ODD, 16'h0001);
    rd(`PTM_ADDR_STATUS);
    wr(`PTM_ADDR_CTRL_EVEN, 16'h8008);
    #1 t0 = cyc;
    repeat (25) @(posedge clk_i);
    rd(`PTM_ADDR_CNT_ODD);
    `CHK("join_carry", 16'h0001, d)
    hit(1'b1, t1);
    `CHK("join_match", 1'b1, t1 - t0 >= 46 && t1 - t0 <= 52)
    `CHK("join_irq", 1'b1, irq_o)
    rd(`PTM_ADDR_STATUS);
    `CHK("join_flag", 16'h0002, d)
    wr(`PTM_ADDR_CTRL_EVEN, 16'h0008);
    rd(`PTM_ADDR_CNT_ODD);
    `CHK("join_wrap", 16'h0000, d)
    rd(`PTM_ADDR_CNT_EVEN);
    `CHK("join_low", 1'b1, d < 16'h0010)
    // Gated accumulation on the internal clock; the odd timer is stopped so its flag stays quiet.
    wr(`PTM_ADDR_CTRL_EVEN, 16'h0000);
    wr(`PTM_ADDR_CTRL_ODD, 16'h0000);
    wr(`PTM_ADDR_CNT_EVEN, 16'h0000);
    wr(`PTM_ADDR_PER_EVEN, 16'hFFFF);
    rd(`PTM_ADDR_STATUS);
    wr(`PTM_ADDR_CTRL_EVEN, 16'h8040);
    repeat (4) @(posedge clk_i);
    gate_e <= 1'b1;
    repeat (12) @(posedge clk_i);
    gate_e <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(`PTM_ADDR_CNT_EVEN);
    `CHK("gated_cnt", 1'b1, d >= 16'h000B && d <= 16'h000D)
    rd(`PTM_ADDR_STATUS);
    `CHK("gated_fall", 16'h0001, d)
    // Idle halt freezes the count; without it counting goes on.
    wr(`PTM_ADDR_CTRL_EVEN, 16'hA000);
    idle_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`PTM_ADDR_CNT_EVEN);
    v = d;
    repeat (10) @(posedge clk_i);
    rd(`PTM_ADDR_CNT_EVEN);
    `CHK("idle_hold", v, d)
    wr(`PTM_ADDR_CTRL_EVEN, 16'h8000);
    repeat (10) @(posedge clk_i);
    rd(`PTM_ADDR_CNT_EVEN);
    `CHK("idle_run", 1'b1, d !== v)
    idle_i <= 1'b0;
    conclude();
  end
endmodule
